// [bench/charge_level_warning_flags_bench.sv]
`timescale 1ns/1ps
module charge_level_warning_flags_bench
	import gauge_pkg::*;
;
	typedef struct {logic [7:0] addr; logic [15:0] exp;} row_type;
	logic        clk_in = 1'b0;
	logic        reset_n_in = 1'b0;
	logic        clk_en_in = 1'b1;
	logic [15:0] sense_input_pos = 16'h8000;
	logic [15:0] sense_input_neg = 16'h8000;
	logic [15:0] cell_voltage_in = 16'h1000;
	logic        sample_valid_in = 1'b0;
	logic [7:0]  addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic [15:0] d;
	logic [15:0] rem;
	logic        wr;
	logic        rd;
	logic        ini;
	logic        fin;
	logic        irq;
	int          mismatches = 0;
	int          checked = 0;
	int          cycles = 0;
	// reset contents of the configuration map, one unmapped place last
	row_type rows [15] = '{'{OFS_REMAIN, ZERO16}, '{OFS_FLAGS, ZERO16},
		'{OFS_INIT_SET, INIT_SET_RST}, '{OFS_INIT_CLR, INIT_CLR_RST},
		'{OFS_FINAL_SET, FINAL_SET_RST}, '{OFS_FINAL_CLR, FINAL_CLR_RST},
		'{OFS_QMAX, QMAX_RST}, '{OFS_GAIN_LO, GAIN_RST[15:0]}, '{OFS_GAIN_HI, GAIN_RST[31:16]},
		'{OFS_DELTA_HI, DELTA_RST[31:16]}, '{OFS_BOARD_OFS, 16'h0000},
		'{OFS_TERM_V, TERM_V_RST}, '{OFS_IRQ_MASK, ZERO16},
		'{OFS_UPDATE_DIV, UPDATE_DIV_RST}, '{8'h20, ZERO16}};
	always #50 clk_in = ~clk_in;
	charge_level_warning_flags i_charge_level_warning_flags (.clk_in(clk_in),
		.reset_n_in(reset_n_in), .clk_en_in(clk_en_in), .sense_input_pos(sense_input_pos),
		.sense_input_neg(sense_input_neg), .cell_voltage_in(cell_voltage_in),
		.sample_valid_in(sample_valid_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
		.rd_in(rd), .rdata_out(rdata), .initial_low_charge_flag_out(ini),
		.final_low_charge_flag_out(fin), .irq_out(irq));
	host_port_model i_host_port_model (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr),
		.wdata_out(wdata), .wr_out(wr), .rd_out(rd));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// wait for the pins under a bound, then check them once 60 cycles later
	task automatic expect_flags(input logic i, input logic f);
		for (int n = 0; n < 300 && {ini, fin} !== {i, f}; n++) begin
			@(posedge clk_in);
		end
		repeat (60) @(posedge clk_in);
		check(16'(ini), 16'(i));
		check(16'(fin), 16'(f));
	endtask
	task automatic expect_reg(input logic [7:0] a, input logic [15:0] e);
		i_host_port_model.read_reg(a, d);
		check(d, e);
	endtask
	// guard against a hang
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 30000) begin
			mismatches++;
			finish_test();
		end
	end
	initial begin
		repeat (2) @(posedge clk_in);
		reset_n_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		foreach (rows[i]) begin
			expect_reg(rows[i].addr, rows[i].exp);
		end
		i_host_port_model.write_reg(OFS_BOARD_OFS, 16'h0080);
		expect_reg(OFS_BOARD_OFS, 16'hff80);
		i_host_port_model.configure();
		expect_reg(OFS_QMAX, 16'h03e8);
		i_host_port_model.write_reg(OFS_IRQ_MASK, 16'h000f);
		// charge hard: flags set at the empty start, then clear as capacity climbs
		sense_input_pos <= 16'hffff;
		sense_input_neg <= 16'h0000;
		sample_valid_in <= 1'b1;
		repeat (4000) @(posedge clk_in);
		sense_input_pos <= 16'h8000;
		sense_input_neg <= 16'h8000;
		repeat (200) @(posedge clk_in);
		i_host_port_model.read_reg(OFS_REMAIN, rem);
		check(16'(rem > INIT_CLR_RST), 16'h0001);
		expect_flags(1'b0, 1'b0);
		expect_reg(OFS_IRQ_STATUS, 16'h000f);
		check(16'(irq), 16'h0001);
		expect_reg(OFS_FULL_AVAIL, QMAX_RST);
		i_host_port_model.read_reg(OFS_NOMINAL, d);
		check(16'(d >= rem), 16'h0001);
		i_host_port_model.read_reg(OFS_FULL_CHARGE, d);
		check(16'(d <= QMAX_RST), 16'h0001);
		i_host_port_model.write_reg(OFS_IRQ_STATUS, 16'h000f);
		expect_reg(OFS_IRQ_STATUS, 16'h0000);
		// final set at minus one must stay silent while initial sets
		i_host_port_model.write_reg(OFS_FINAL_SET, FINAL_DISABLED);
		i_host_port_model.write_reg(OFS_INIT_SET, 16'hffff);
		expect_flags(1'b1, 1'b0);
		expect_reg(OFS_FLAGS, 16'h0001 << FLAG_INITIAL_BIT);
		expect_reg(OFS_IRQ_STATUS, 16'h0001);
		i_host_port_model.write_reg(OFS_INIT_CLR, 16'hffff);
		i_host_port_model.write_reg(OFS_INIT_SET, 16'h0000);
		expect_flags(1'b1, 1'b0);
		i_host_port_model.write_reg(OFS_INIT_CLR, 16'h0000);
		expect_flags(1'b0, 1'b0);
		i_host_port_model.write_reg(OFS_FINAL_CLR, 16'h0000);
		expect_flags(1'b0, 1'b0);
		expect_reg(OFS_IRQ_STATUS, 16'h0003);
		i_host_port_model.write_reg(OFS_FINAL_SET, 16'hfffe);
		expect_flags(1'b0, 1'b1);
		expect_reg(OFS_FLAGS, 16'h0001 << FLAG_FINAL_BIT);
		i_host_port_model.write_reg(OFS_FINAL_SET, 16'h0000);
		i_host_port_model.write_reg(OFS_FINAL_CLR, 16'hffff);
		expect_flags(1'b0, 1'b1);
		i_host_port_model.write_reg(OFS_FINAL_CLR, 16'h0000);
		expect_flags(1'b0, 1'b0);
		expect_reg(OFS_IRQ_STATUS, 16'h000f);
		// masking drops the level, unmasking one pending bit raises it
		i_host_port_model.write_reg(OFS_IRQ_MASK, 16'h0000);
		repeat (2) @(posedge clk_in);
		check(16'(irq), 16'h0000);
		i_host_port_model.write_reg(OFS_IRQ_MASK, 16'h0008);
		repeat (2) @(posedge clk_in);
		check(16'(irq), 16'h0001);
		clk_en_in <= 1'b0;
		repeat (30) @(posedge clk_in);
		clk_en_in <= 1'b1;
		// discharge under load: capacity falls, loaded voltage sags below the model
		cell_voltage_in <= 16'h0c80;
		sense_input_pos <= 16'h0000;
		sense_input_neg <= 16'hffff;
		repeat (1500) @(posedge clk_in);
		expect_reg(OFS_VOLTAGE, 16'h0c80);
		i_host_port_model.read_reg(OFS_REMAIN, d);
		check(16'(d < rem), 16'h0001);
		i_host_port_model.read_reg(OFS_NOMINAL, d);
		check(16'(d < QMAX_RST), 16'h0001);
		i_host_port_model.read_reg(OFS_IMPEDANCE, d);
		check(16'(d != 16'h0000), 16'h0001);
		// second reset in mid-run clears the pending interrupt
		reset_n_in <= 1'b0;
		@(posedge clk_in);
		check(16'(irq), 16'h0000);
		reset_n_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		expect_reg(OFS_IRQ_STATUS, 16'h0000);
		finish_test();
	end
endmodule

// [bench/gauge_flags_chk.sv]
`timescale 1ns/1ps
module gauge_flags_chk
	import gauge_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              reset_n_in,
	input  wire logic              clk_en_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [DATA_W-1:0] wdata_in,
	input  wire logic              wr_in,
	input  wire logic              rd_in,
	input  wire logic [DATA_W-1:0] rdata_out,
	input  wire logic              initial_low_charge_flag_out,
	input  wire logic              final_low_charge_flag_out,
	input  wire logic              irq_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	// bus strobes as the register port takes them
	sequence rd_taken(logic [7:0] a);
		rd_in && clk_en_in && addr_in == a;
	endsequence
	sequence wr_taken(logic [7:0] a, logic [15:0] d);
		wr_in && clk_en_in && addr_in == a && wdata_in == d;
	endsequence
	// a flag pin never moves twice inside one gauge pass
	sequence held_three(logic s);
		$stable(s) [*3];
	endsequence
	idle_read_zero_a: assert property (clk_en_in && !rd_in |=> rdata_out == 16'h0000)
		else $error("read data not zero outside a read");
	unmapped_zero_a: assert property (rd_in && clk_en_in && addr_in > OFS_UPDATE_DIV
		|=> rdata_out == 16'h0000) else $error("unmapped read not zero");
	flags_read_a: assert property (rd_taken(OFS_FLAGS) |=>
		rdata_out[FLAG_INITIAL_BIT] == initial_low_charge_flag_out
		&& rdata_out[FLAG_FINAL_BIT] == final_low_charge_flag_out)
		else $error("flag word disagrees with flag pins");
	freeze_flags_a: assert property (!clk_en_in |=> $stable(initial_low_charge_flag_out)
		&& $stable(final_low_charge_flag_out)) else $error("flag moved while frozen");
	freeze_bus_a: assert property (!clk_en_in |=> $stable(rdata_out) && $stable(irq_out))
		else $error("bus or irq moved while frozen");
	initial_spacing_a: assert property ($changed(initial_low_charge_flag_out)
		|=> held_three(initial_low_charge_flag_out)) else $error("initial flag chatter");
	final_spacing_a: assert property ($changed(final_low_charge_flag_out)
		|=> held_three(final_low_charge_flag_out)) else $error("final flag chatter");
	reset_quiet_a: assert property ($rose(reset_n_in) |-> (!initial_low_charge_flag_out
		&& !final_low_charge_flag_out && !irq_out) [*2]) else $error("outputs busy after reset");
	mask_quiet_a: assert property (wr_taken(OFS_IRQ_MASK, 16'h0000) |-> ##[1:2] !irq_out)
		else $error("irq high with all masked");
	clear_quiet_a: assert property (wr_taken(OFS_IRQ_STATUS, 16'h000f) |-> ##[1:2] !irq_out)
		else $error("irq high after status clear");
endmodule
bind charge_level_warning_flags gauge_flags_chk i_gauge_flags_chk (.clk_in(clk_in),
	.reset_n_in(reset_n_in), .clk_en_in(clk_en_in), .addr_in(addr_in), .wdata_in(wdata_in),
	.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out),
	.initial_low_charge_flag_out(initial_low_charge_flag_out),
	.final_low_charge_flag_out(final_low_charge_flag_out));

// [bench/host_port_model.sv]
`timescale 1ns/1ps
// host processor on the register port; strobes move just after an edge
module host_port_model
	import gauge_pkg::*;
#(
	parameter int RATED_MAH = 500,
	parameter int PARALLEL  = 2
)(
	input  wire logic              clk_in,
	input  wire logic [DATA_W-1:0] rdata_in,
	output logic [ADDR_W-1:0]      addr_out,
	output logic [DATA_W-1:0]      wdata_out,
	output logic                   wr_out,
	output logic                   rd_out
);
	initial begin
		addr_out = 8'h00;
		wdata_out = 16'h0000;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end
	task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'b1;
		@(posedge clk_in);
		wr_out <= 1'b0;
	endtask
	// answer stands only in the cycle after the strobe, taken at its closing edge
	task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge clk_in);
		rd_out <= 1'b0;
		@(posedge clk_in);
		d = rdata_in;
	endtask
	// capacity is rated capacity times parallel count; gain trim of 1.0 in own 16.16 form
	task automatic configure();
		write_reg(OFS_QMAX, 16'(RATED_MAH * PARALLEL));
		write_reg(OFS_GAIN_LO, 16'h0000);
		write_reg(OFS_GAIN_HI, 16'h0001);
	endtask
endmodule

// [design/charge_level_warning_flags.sv]
`timescale 1ns/1ps
// Overview of operation
// RULE1: set initial flag when remaining capacity falls below initial set level (mAh).
// RULE2: clear initial flag only when capacity rises above initial clear level.
// RULE3: set final flag when remaining capacity falls below final set level.
// RULE4: final set level of minus one disables final flag setting.
// RULE5: clear final flag only if set and capacity rises above final clear level.
// RULE6: integrate sense-resistor voltage to track charge both directions.
// RULE7: under load, impedance from predicted ocv minus measured loaded voltage.
// RULE8: host loads qmax as rated capacity times parallel cells; also design capacity.
// RULE9: full charge capacity is capacity from full under load to termination voltage.
// RULE10: nominal and full available capacities are uncompensated light-load values.
// RULE11: gain and delta trims use own fixed format, not ieee float.
// RULE12: board offset trim is signed byte, -128 to 127, reset zero.
// RULE13: both flags re-evaluated at every remaining capacity update.
module charge_level_warning_flags
	import gauge_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              reset_n_in,
	input  wire logic              clk_en_in,
	input  wire logic [ADC_W-1:0]  sense_input_pos,
	input  wire logic [ADC_W-1:0]  sense_input_neg,
	input  wire logic [15:0]       cell_voltage_in,
	input  wire logic              sample_valid_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [DATA_W-1:0] wdata_in,
	input  wire logic              wr_in,
	input  wire logic              rd_in,
	output logic [DATA_W-1:0]      rdata_out,
	output logic                   initial_low_charge_flag_out,
	output logic                   final_low_charge_flag_out,
	output logic                   irq_out
);
	// reset release through two flops
	// assert is immediate, release waits two edges
	logic rst_s1_r;
	logic rst_n;
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rst_s1_r <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n    <= rst_s1_r;
		end
	end

	// pin inputs: two flops before use
	// words are not handshaked: the source holds them while valid is up
	logic [ADC_W-1:0] pos_s1_r;
	logic [ADC_W-1:0] pos_s2_r;
	logic [ADC_W-1:0] neg_s1_r;
	logic [ADC_W-1:0] neg_s2_r;
	logic [15:0]      volt_s1_r;
	logic [15:0]      volt_s2_r;
	logic             vld_s1_r;
	logic             vld_s2_r;
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			pos_s1_r  <= '0;
			pos_s2_r  <= '0;
			neg_s1_r  <= '0;
			neg_s2_r  <= '0;
			volt_s1_r <= '0;
			volt_s2_r <= '0;
			vld_s1_r  <= 1'b0;
			vld_s2_r  <= 1'b0;
		end else if (clk_en_in) begin
			pos_s1_r  <= sense_input_pos;
			pos_s2_r  <= pos_s1_r;
			neg_s1_r  <= sense_input_neg;
			neg_s2_r  <= neg_s1_r;
			volt_s1_r <= cell_voltage_in;
			volt_s2_r <= volt_s1_r;
			vld_s1_r  <= sample_valid_in;
			vld_s2_r  <= vld_s1_r;
		end
	end

	// configuration registers
	logic [15:0]      init_set_r;
	logic [15:0]      init_clr_r;
	logic [15:0]      final_set_r;
	logic [15:0]      final_clr_r;
	logic [15:0]      qmax_r;
	logic [15:0]      term_v_r;
	logic [15:0]      update_div_r;
	logic [31:0]      gain_r;
	logic [31:0]      delta_r;
	logic [7:0]       board_ofs_r;
	logic [IRQ_W-1:0] irq_status_r;
	logic [IRQ_W-1:0] irq_mask_r;

	// gauge state
	gauge_state_type state_r;
	logic [ACC_W-1:0] charge_acc_r;
	logic [CAP_W-1:0]        remain_r;
	logic [CAP_W-1:0]        full_charge_r;
	logic [CAP_W-1:0]        nominal_r;
	logic [CAP_W-1:0]        full_avail_r;
	logic [15:0]             impedance_r;
	logic [15:0]             voltage_r;
	logic [15:0]             tick_cnt_r;
	// one bit wider than a raw difference: the offset can push past it
	logic signed [ADC_W+1:0] sense_diff_r;

	// write decode
	// writes to read-only places are ignored
	wire wr_init_set  = wr_in && (addr_in == OFS_INIT_SET);
	wire wr_init_clr  = wr_in && (addr_in == OFS_INIT_CLR);
	wire wr_final_set = wr_in && (addr_in == OFS_FINAL_SET);
	wire wr_final_clr = wr_in && (addr_in == OFS_FINAL_CLR);
	wire wr_qmax      = wr_in && (addr_in == OFS_QMAX);
	wire wr_gain_lo   = wr_in && (addr_in == OFS_GAIN_LO);
	wire wr_gain_hi   = wr_in && (addr_in == OFS_GAIN_HI);
	wire wr_delta_lo  = wr_in && (addr_in == OFS_DELTA_LO);
	wire wr_delta_hi  = wr_in && (addr_in == OFS_DELTA_HI);
	wire wr_board     = wr_in && (addr_in == OFS_BOARD_OFS);
	wire wr_term_v    = wr_in && (addr_in == OFS_TERM_V);
	wire wr_irq_stat  = wr_in && (addr_in == OFS_IRQ_STATUS);
	wire wr_irq_mask  = wr_in && (addr_in == OFS_IRQ_MASK);
	wire wr_div       = wr_in && (addr_in == OFS_UPDATE_DIV);

	// config writes; qmax is host loaded and doubles as design capacity
	// trim halves land separately; write both before relying on them
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			init_set_r   <= INIT_SET_RST;
			init_clr_r   <= INIT_CLR_RST;
			final_set_r  <= FINAL_SET_RST;
			final_clr_r  <= FINAL_CLR_RST;
			qmax_r       <= QMAX_RST;
			gain_r       <= GAIN_RST;
			delta_r      <= DELTA_RST;
			board_ofs_r  <= BOARD_OFS_RST; // see RULE12
			term_v_r     <= TERM_V_RST;
			irq_mask_r   <= '0;
			update_div_r <= UPDATE_DIV_RST;
		end else if (clk_en_in) begin
			if (wr_init_set)  init_set_r  <= wdata_in;
			if (wr_init_clr)  init_clr_r  <= wdata_in;
			if (wr_final_set) final_set_r <= wdata_in;
			if (wr_final_clr) final_clr_r <= wdata_in;
			if (wr_qmax)      qmax_r      <= wdata_in; // see RULE8
			if (wr_gain_lo)   gain_r[15:0]  <= wdata_in; // see RULE11
			if (wr_gain_hi)   gain_r[31:16] <= wdata_in;
			if (wr_delta_lo)  delta_r[15:0]  <= wdata_in;
			if (wr_delta_hi)  delta_r[31:16] <= wdata_in;
			if (wr_board)     board_ofs_r <= wdata_in[7:0]; // see RULE12
			if (wr_term_v)    term_v_r    <= wdata_in;
			if (wr_irq_mask)  irq_mask_r  <= wdata_in[IRQ_W-1:0];
			if (wr_div)       update_div_r <= wdata_in;
		end
	end

	// sense difference with signed board offset; a full-scale difference
	// plus the offset needs one bit more than the difference alone
	wire signed [ADC_W:0] raw_diff = $signed({1'b0, pos_s2_r}) - $signed({1'b0, neg_s2_r});
	wire signed [ADC_W:0] board_ext = {{(ADC_W-7){board_ofs_r[7]}}, board_ofs_r};
	wire signed [ADC_W+1:0] sense_sum = raw_diff + board_ext; // see RULE12
	// gain in 16.16 fixed point; product truncated back to accumulator width
	wire signed [50:0] gained = 51'(sense_sum) * $signed({1'b0, gain_r});
	wire signed [ACC_W-1:0] charge_step = ACC_W'(gained >>> TRIM_FRAC);
	// floor at empty and stop at qmax: a wrap below zero would read
	// back as a full cell, and charge past full is not stored
	wire [ACC_W-1:0] acc_sum   = charge_acc_r + charge_step;
	wire             acc_under = charge_step[ACC_W-1] && (acc_sum > charge_acc_r);
	wire [ACC_W-1:0] acc_full  = {16'h0000, qmax_r} << CHARGE_SHIFT;
	wire [ACC_W-1:0] acc_next  = acc_under ? '0 : ((acc_sum > acc_full) ? acc_full : acc_sum);

	// capacity in mAh derived from accumulator, clamped to qmax
	wire [ACC_W-1:0] acc_cap   = charge_acc_r >> CHARGE_SHIFT;
	wire [CAP_W-1:0] nom_cap   = (acc_cap > {16'h0000, qmax_r}) ? qmax_r : acc_cap[CAP_W-1:0];
	// predicted ocv for present charge, linear in soc
	wire [31:0] soc_span  = {16'h0000, nom_cap} * {16'h0000, OCV_SPAN_MV};
	// qmax of zero gives a zero fraction instead of a divide
	wire [15:0] soc_frac  = (qmax_r == ZERO16) ? ZERO16 : 16'(soc_span / {16'h0000, qmax_r});
	wire [15:0] ocv_pred  = OCV_EMPTY_MV + soc_frac;
	wire        loaded    = sense_diff_r < 0;
	wire [15:0] ocv_drop  = (ocv_pred > voltage_r) ? (ocv_pred - voltage_r) : ZERO16;
	// capacity lost below termination: impedance drop scaled by delta, saturating
	wire [15:0] margin    = (ocv_pred > term_v_r) ? (ocv_pred - term_v_r) : ZERO16;
	wire [47:0] loss_prod = {32'h0, impedance_r} * delta_r;
	wire [15:0] loss_cap  = (loss_prod[47:32] != 16'h0) ? 16'hffff : loss_prod[31:16];
	wire [15:0] full_comp = (qmax_r > loss_cap) ? (qmax_r - loss_cap) : ZERO16;
	wire [15:0] rem_comp  = (nom_cap > loss_cap) ? (nom_cap - loss_cap) : ZERO16;
	// every (update_div+1)th sample refreshes capacities and flags
	wire        tick_done = (tick_cnt_r >= update_div_r);
	wire        eval_flags = (state_r == ST_FLAGS);
	wire        final_off  = (final_set_r == FINAL_DISABLED);

	// gauge sequence: integrate, compute capacities, evaluate flags
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			state_r       <= ST_IDLE;
			charge_acc_r  <= '0;
			sense_diff_r  <= '0;
			voltage_r     <= '0;
			impedance_r   <= '0;
			tick_cnt_r    <= '0;
			remain_r      <= '0;
			full_charge_r <= '0;
			nominal_r     <= '0;
			full_avail_r  <= '0;
		end else if (clk_en_in) begin
			case (state_r)
				ST_IDLE: begin
					// samples arriving outside idle are dropped
					if (vld_s2_r) begin
						sense_diff_r <= sense_sum;
						voltage_r    <= volt_s2_r;
						state_r      <= ST_INTEG;
					end
				end
				ST_INTEG: begin
					// signed step counts charge and discharge alike
					charge_acc_r <= acc_next; // see RULE6
					tick_cnt_r   <= tick_done ? ZERO16 : tick_cnt_r + 16'h0001;
					state_r      <= tick_done ? ST_CAPCALC : ST_IDLE;
				end
				ST_CAPCALC: begin
					// impedance only refreshed while load drawn
					// remaining uses the impedance of the previous pass
					if (loaded)
						impedance_r <= ocv_drop; // see RULE7
					full_charge_r <= (margin == ZERO16) ? ZERO16 : full_comp; // see RULE9
					remain_r      <= (margin == ZERO16) ? ZERO16 : rem_comp;
					nominal_r     <= nom_cap; // see RULE10
					full_avail_r  <= qmax_r; // see RULE10
					state_r       <= ST_FLAGS;
				end
				ST_FLAGS: begin
					state_r <= ST_IDLE; // see RULE13
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	logic init_flag;
	logic final_flag;
	logic init_set_p;
	logic init_clr_p;
	logic final_set_p;
	logic final_clr_p;

	// initial warning with its own set and clear levels
	hyst_flag u_initial (
		.clk_in          (clk_in),
		.rst_n_in        (rst_n),
		.en_in           (clk_en_in),
		.eval_in         (eval_flags), // see RULE13
		.level_in        (remain_r),
		.set_level_in    (init_set_r), // see RULE1
		.clear_level_in  (init_clr_r), // see RULE2
		.set_disable_in  (1'b0),
		.flag_out        (init_flag),
		.set_pulse_out   (init_set_p),
		.clear_pulse_out (init_clr_p)
	);

	// final warning; clear only when already set
	// minus one as set level turns only the set side off
	hyst_flag u_final (
		.clk_in          (clk_in),
		.rst_n_in        (rst_n),
		.en_in           (clk_en_in),
		.eval_in         (eval_flags), // see RULE13
		.level_in        (remain_r),
		.set_level_in    (final_set_r), // see RULE3
		.clear_level_in  (final_clr_r), // see RULE5
		.set_disable_in  (final_off), // see RULE4
		.flag_out        (final_flag),
		.set_pulse_out   (final_set_p),
		.clear_pulse_out (final_clr_p)
	);

	// sticky events; a new event wins over a write-one clear
	// level moves on the same edge as status, and one edge after a mask write
	wire [IRQ_W-1:0] irq_events = {final_clr_p, final_set_p, init_clr_p, init_set_p};
	wire [IRQ_W-1:0] irq_clear  = wr_irq_stat ? wdata_in[IRQ_W-1:0] : '0;
	wire [IRQ_W-1:0] irq_nxt    = (irq_status_r & ~irq_clear) | irq_events;
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			irq_status_r <= '0;
			irq_out      <= 1'b0;
		end else if (clk_en_in) begin
			irq_status_r <= irq_nxt;
			irq_out      <= |(irq_nxt & irq_mask_r);
		end
	end

	// flag word and pin copies
	// built from the internal flags, so a read agrees with the pins
	wire [15:0] flag_word = (16'(init_flag) << FLAG_INITIAL_BIT)
		| (16'(final_flag) << FLAG_FINAL_BIT);
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			initial_low_charge_flag_out <= 1'b0;
			final_low_charge_flag_out   <= 1'b0;
		end else if (clk_en_in) begin
			initial_low_charge_flag_out <= init_flag;
			final_low_charge_flag_out   <= final_flag;
		end
	end

	// read mux; unmapped addresses read zero
	logic [15:0] rd_mux;
	always_comb begin
		if (addr_in == OFS_REMAIN)           rd_mux = remain_r;
		else if (addr_in == OFS_FULL_CHARGE) rd_mux = full_charge_r;
		else if (addr_in == OFS_NOMINAL)     rd_mux = nominal_r;
		else if (addr_in == OFS_FULL_AVAIL)  rd_mux = full_avail_r;
		else if (addr_in == OFS_FLAGS)       rd_mux = flag_word;
		else if (addr_in == OFS_INIT_SET)    rd_mux = init_set_r;
		else if (addr_in == OFS_INIT_CLR)    rd_mux = init_clr_r;
		else if (addr_in == OFS_FINAL_SET)   rd_mux = final_set_r;
		else if (addr_in == OFS_FINAL_CLR)   rd_mux = final_clr_r;
		else if (addr_in == OFS_QMAX)        rd_mux = qmax_r;
		else if (addr_in == OFS_GAIN_LO)     rd_mux = gain_r[15:0];
		else if (addr_in == OFS_GAIN_HI)     rd_mux = gain_r[31:16];
		else if (addr_in == OFS_DELTA_LO)    rd_mux = delta_r[15:0];
		else if (addr_in == OFS_DELTA_HI)    rd_mux = delta_r[31:16];
		else if (addr_in == OFS_BOARD_OFS)   rd_mux = {{8{board_ofs_r[7]}}, board_ofs_r};
		else if (addr_in == OFS_TERM_V)      rd_mux = term_v_r;
		else if (addr_in == OFS_VOLTAGE)     rd_mux = voltage_r;
		else if (addr_in == OFS_IMPEDANCE)   rd_mux = impedance_r;
		else if (addr_in == OFS_IRQ_STATUS)  rd_mux = {12'h000, irq_status_r};
		else if (addr_in == OFS_IRQ_MASK)    rd_mux = {12'h000, irq_mask_r};
		else if (addr_in == OFS_UPDATE_DIV)  rd_mux = update_div_r;
		else                                 rd_mux = ZERO16;
	end

	// read data valid only in the cycle after the strobe
	// a strobe while frozen is lost; keep the enable high
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n)
			rdata_out <= '0;
		else if (clk_en_in)
			rdata_out <= rd_in ? rd_mux : ZERO16;
	end
endmodule

// [design/gauge_pkg.sv]
package gauge_pkg;
	// widths
	localparam int CAP_W    = 16;
	localparam int ADC_W    = 16;
	localparam int ACC_W    = 32;
	localparam int ADDR_W   = 8;
	localparam int DATA_W   = 16;
	// register offsets
	localparam logic [7:0] OFS_REMAIN      = 8'h00;
	localparam logic [7:0] OFS_FULL_CHARGE = 8'h01;
	localparam logic [7:0] OFS_NOMINAL     = 8'h02;
	localparam logic [7:0] OFS_FULL_AVAIL  = 8'h03;
	localparam logic [7:0] OFS_FLAGS       = 8'h04;
	localparam logic [7:0] OFS_INIT_SET    = 8'h05;
	localparam logic [7:0] OFS_INIT_CLR    = 8'h06;
	localparam logic [7:0] OFS_FINAL_SET   = 8'h07;
	localparam logic [7:0] OFS_FINAL_CLR   = 8'h08;
	localparam logic [7:0] OFS_QMAX        = 8'h09;
	localparam logic [7:0] OFS_GAIN_LO     = 8'h0a;
	localparam logic [7:0] OFS_GAIN_HI     = 8'h0b;
	localparam logic [7:0] OFS_DELTA_LO    = 8'h0c;
	localparam logic [7:0] OFS_DELTA_HI    = 8'h0d;
	localparam logic [7:0] OFS_BOARD_OFS   = 8'h0e;
	localparam logic [7:0] OFS_TERM_V      = 8'h0f;
	localparam logic [7:0] OFS_VOLTAGE     = 8'h10;
	localparam logic [7:0] OFS_IMPEDANCE   = 8'h11;
	localparam logic [7:0] OFS_IRQ_STATUS  = 8'h12;
	localparam logic [7:0] OFS_IRQ_MASK    = 8'h13;
	localparam logic [7:0] OFS_UPDATE_DIV  = 8'h14;
	// flag word bit positions
	localparam int FLAG_FINAL_BIT   = 1;
	localparam int FLAG_INITIAL_BIT = 2;
	// interrupt status bit positions
	localparam int IRQ_INIT_SET  = 0;
	localparam int IRQ_INIT_CLR  = 1;
	localparam int IRQ_FINAL_SET = 2;
	localparam int IRQ_FINAL_CLR = 3;
	localparam int IRQ_W         = 4;
	// reset values
	localparam logic [15:0] INIT_SET_RST    = 16'h0096;
	localparam logic [15:0] INIT_CLR_RST    = 16'h00af;
	localparam logic [15:0] FINAL_SET_RST   = 16'h004b;
	localparam logic [15:0] FINAL_CLR_RST   = 16'h0064;
	localparam logic [15:0] FINAL_DISABLED  = 16'hffff;
	localparam logic [15:0] QMAX_RST        = 16'h03e8;
	localparam logic [15:0] TERM_V_RST      = 16'h0bb8;
	localparam logic [31:0] GAIN_RST        = 32'h00010000;
	localparam logic [31:0] DELTA_RST       = 32'h00010000;
	localparam logic [7:0]  BOARD_OFS_RST   = 8'h00;
	localparam logic [15:0] UPDATE_DIV_RST  = 16'h0003;
	localparam logic [15:0] ZERO16          = 16'h0000;
	// trim format: unsigned 16.16 fixed point, own layout, not ieee
	localparam int TRIM_FRAC = 16;
	// coulomb counter: accumulator units of charge per capacity lsb
	localparam int CHARGE_SHIFT = 16;
	// simple ocv model: ocv = empty voltage + slope * soc fraction
	localparam logic [15:0] OCV_EMPTY_MV = 16'h0bb8;
	localparam logic [15:0] OCV_SPAN_MV  = 16'h04b0;
	// light-load estimate: impedance scales loss; full load current in mA
	localparam logic [15:0] LOAD_FULL_MA = 16'h03e8;
	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_INTEG   = 2'b01,
		ST_CAPCALC = 2'b10,
		ST_FLAGS   = 2'b11
	} gauge_state_type;
endpackage

// [design/hyst_flag.sv]
`timescale 1ns/1ps
// one warning flag with set and clear hysteresis
module hyst_flag
	import gauge_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              rst_n_in,
	input  wire logic              en_in,
	input  wire logic              eval_in,
	input  wire logic [CAP_W-1:0]  level_in,
	input  wire logic [15:0]       set_level_in,
	input  wire logic [15:0]       clear_level_in,
	input  wire logic              set_disable_in,
	output logic                   flag_out,
	output logic                   set_pulse_out,
	output logic                   clear_pulse_out
);
	wire below_set   = (level_in < set_level_in) && !set_disable_in;
	wire above_clear = flag_out && (level_in > clear_level_in);
	wire do_set      = eval_in && !flag_out && below_set;
	wire do_clear    = eval_in && above_clear && !below_set;

	// flag held between thresholds gives the hysteresis
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			flag_out        <= 1'b0;
			set_pulse_out   <= 1'b0;
			clear_pulse_out <= 1'b0;
		end else if (en_in) begin
			set_pulse_out   <= do_set;
			clear_pulse_out <= do_clear;
			if (do_set)
				flag_out <= 1'b1;
			else if (do_clear)
				flag_out <= 1'b0;
		end
	end
endmodule
